// ===== logic/tension_pkg.sv
// Purpose: constants and types shared by the tension status area logic
// Assumes: 25 MHz system clock, area reached only through byte messages
// Notes: offsets are byte numbers within the 16 byte communication area
`default_nettype none
package tension_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned FLASH_MS = 250; // led half period in ms
    localparam int unsigned FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_MS;
    // area offsets
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_TLOW = 4'h2;
    localparam logic [3:0] OFS_HI_IND_MSB = 4'h3;
    localparam logic [3:0] OFS_HI_IND_LSB = 4'h4;
    localparam logic [3:0] OFS_LO_IND_MSB = 4'h5;
    localparam logic [3:0] OFS_LO_IND_LSB = 4'h6;
    localparam logic [3:0] OFS_HI_STOP_MSB = 4'h7;
    localparam logic [3:0] OFS_HI_STOP_LSB = 4'h8;
    localparam logic [3:0] OFS_LO_STOP_MSB = 4'h9;
    localparam logic [3:0] OFS_LO_STOP_LSB = 4'hA;
    localparam logic [3:0] OFS_FILTER = 4'hD;
    localparam logic [3:0] OFS_LAST = 4'hF;
    localparam logic [1:0] REPORT_LAST = 2'h2; // three report bytes
    // command byte fields
    localparam int unsigned CMD_READ_BIT = 5;
    localparam int unsigned CMD_MODE_MSB = 7;
    localparam int unsigned CMD_MODE_LSB = 6;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_EVERY = 2'h2;
    localparam logic [1:0] MODE_EVENT = 2'h3;
    // status byte fields
    localparam int unsigned STAT_LO_STOP = 4;
    localparam int unsigned STAT_HI_STOP = 5;
    localparam int unsigned STAT_LO_IND = 6;
    localparam int unsigned STAT_HI_IND = 7;
    // values after reset
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_HI_STOP_LSB = 8'h01;
    localparam logic [7:0] RST_LO_STOP = 8'hFF;
    localparam logic [7:0] RST_FILTER = 8'h01;
    // one received byte of a host message
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [7:0] data;
    } rx_byte_type;
    // end of a host message
    typedef struct packed {
        logic done;
        logic good;
    } rx_end_type;
    // transmitter sequencing
    typedef enum {TX_IDLE, TX_AREA, TX_REPORT} tx_state_type;
endpackage : tension_pkg
`default_nettype wire

// ===== logic/limit_check.sv
// Purpose: one limit comparison with stop filter qualification
// Assumes: stitch_i is a one cycle pulse per accepted stitch
// Notes: a zero limit pair disables the test and clears the flag
`default_nettype none
module limit_check (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // per stitch inputs
    input wire logic stitch_i,
    input wire logic enable_i,
    input wire logic out_i,
    input wire logic [3:0] filter_i,
    // qualified flag
    output logic flag_o
);
    logic [3:0] run; // stitches in a row out of limit
    logic [3:0] eff_filter; // zero filter treated as one
    logic [4:0] run_next;

    // count this stitch before comparing with the filter
    always_comb begin
        eff_filter = (filter_i == 4'h0) ? 4'h1 : filter_i;
        run_next = {1'b0, run} + 5'h01;
    end

    // saturating run counter and flag, both only move on a stitch
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run <= 4'h0;
            flag_o <= 1'b0;
        end else if (stitch_i) begin
            if (enable_i && out_i) begin
                run <= (run == 4'hF) ? run : run_next[3:0];
                flag_o <= (run_next >= {1'b0, eff_filter});
            end else begin
                run <= 4'h0;
                flag_o <= 1'b0;
            end
        end
    end
endmodule : limit_check
`default_nettype wire

// ===== logic/tension_area.sv
// Purpose: low part of the thread tension monitor communication area
// Assumes: serial framing, parity and checksum checks sit outside
// Notes: host writes arrive as indexed bytes closed by an end marker
`default_nettype none
module tension_area #(
    parameter int unsigned FLASH_CYCLES = tension_pkg::FLASH_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // machine side
    input wire logic sync_i,
    input wire logic [11:0] tension_i,
    // host message receive side
    input wire tension_pkg::rx_byte_type rx_i,
    input wire tension_pkg::rx_end_type rx_end_i,
    // host transmit side
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // alert and indicators
    output logic alert_o,
    output logic halted_o,
    output logic [3:0] led_o
);
    // synchroniser and edge detect for the sync pin
    logic sync_meta;
    logic sync_s;
    logic sync_d;
    logic sync_rise;
    // area storage
    logic [7:0] shadow [16]; // message under reception
    logic [7:0] cmd; // command byte
    logic [7:0] cfg [3:15]; // limits, filter, range, checksum
    logic [3:0] tension_hi; // upper tension bits
    logic [7:0] tension_low; // lower tension bits
    logic [7:0] status; // composed status byte
    // measurement control
    logic comm_seen; // any host byte since power on
    logic first_sync_seen;
    logic force_stop; // both stop flags forced
    logic stitch_take; // accepted stitch this cycle
    logic stitch_done; // flags settled one cycle later
    logic [11:0] tension_now;
    logic [3:0] flag; // hi_ind, lo_ind, hi_stop, lo_stop
    logic [15:0] hi_ind_lim;
    logic [15:0] lo_ind_lim;
    logic [15:0] hi_stop_lim;
    logic [15:0] lo_stop_lim;
    logic [1:0] mode;
    logic area_write; // good message that modifies the area
    // transmitter
    tension_pkg::tx_state_type state;
    logic [3:0] tx_idx;
    logic area_pend;
    logic report_pend;
    logic report_go; // stitch result wants a report
    logic tx_take;
    logic [7:0] report_sum;
    // led flashing
    logic [31:0] flash_cnt;
    logic flash;

    // two flops before the sync pin is looked at
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_meta <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sync_meta <= sync_i;
            sync_s <= sync_meta;
            sync_d <= sync_s;
        end
    end

    // derived terms; a halted monitor ignores stitches
    always_comb begin
        sync_rise = sync_s && !sync_d;
        stitch_take = sync_rise && !halted_o;
        tension_now = tension_i;
        mode = cmd[tension_pkg::CMD_MODE_MSB:tension_pkg::CMD_MODE_LSB];
        area_write = rx_end_i.done && rx_end_i.good
            && !shadow[tension_pkg::OFS_CMD][tension_pkg::CMD_READ_BIT];
        hi_ind_lim = {cfg[tension_pkg::OFS_HI_IND_MSB], cfg[tension_pkg::OFS_HI_IND_LSB]};
        lo_ind_lim = {cfg[tension_pkg::OFS_LO_IND_MSB], cfg[tension_pkg::OFS_LO_IND_LSB]};
        hi_stop_lim = {cfg[tension_pkg::OFS_HI_STOP_MSB], cfg[tension_pkg::OFS_HI_STOP_LSB]};
        lo_stop_lim = {cfg[tension_pkg::OFS_LO_STOP_MSB], cfg[tension_pkg::OFS_LO_STOP_LSB]};
        // flags and upper tension bits share one read only byte
        status = {flag[3], flag[2], flag[1] | force_stop, flag[0] | force_stop,
                  tension_hi};
        report_sum = status + tension_low; // simple byte sum
        tx_valid_o = (state != tension_pkg::TX_IDLE);
        tx_take = tx_valid_o && tx_ready_i;
    end

    // four limit tests, each filtered by the stop filter count
    limit_check u_hi_ind (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .stitch_i(stitch_take), .enable_i(hi_ind_lim != 16'h0000),
        .out_i({4'h0, tension_now} > hi_ind_lim),
        .filter_i(cfg[tension_pkg::OFS_FILTER][3:0]), .flag_o(flag[3]));
    limit_check u_lo_ind (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .stitch_i(stitch_take), .enable_i(lo_ind_lim != 16'h0000),
        .out_i({4'h0, tension_now} < lo_ind_lim),
        .filter_i(cfg[tension_pkg::OFS_FILTER][3:0]), .flag_o(flag[2]));
    limit_check u_hi_stop (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .stitch_i(stitch_take), .enable_i(hi_stop_lim != 16'h0000),
        .out_i({4'h0, tension_now} > hi_stop_lim),
        .filter_i(cfg[tension_pkg::OFS_FILTER][3:0]), .flag_o(flag[1]));
    limit_check u_lo_stop (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .stitch_i(stitch_take), .enable_i(lo_stop_lim != 16'h0000),
        .out_i({4'h0, tension_now} < lo_stop_lim),
        .filter_i(cfg[tension_pkg::OFS_FILTER][3:0]), .flag_o(flag[0]));

    // latest stitch tension, split over two read only bytes
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tension_hi <= 4'h0;
            tension_low <= tension_pkg::RST_ZERO;
            stitch_done <= 1'b0;
        end else begin
            stitch_done <= stitch_take;
            if (stitch_take) begin
                tension_hi <= tension_now[11:8];
                tension_low <= tension_now[7:0];
            end
        end
    end

    // no host traffic before the first sync forces both stop flags
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            comm_seen <= 1'b0;
            first_sync_seen <= 1'b0;
            force_stop <= 1'b0;
        end else begin
            if (rx_i.valid) begin
                comm_seen <= 1'b1;
            end
            if (stitch_take) begin
                first_sync_seen <= 1'b1;
                force_stop <= !first_sync_seen && !comm_seen;
            end
        end
    end

    // bytes are held aside until the message closes, so a bad one writes nothing
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 16; i++) begin
                shadow[i] <= tension_pkg::RST_ZERO;
            end
        end else if (rx_i.valid) begin
            shadow[rx_i.index] <= rx_i.data;
        end
    end

    // writable area bytes; read only bytes 1 and 2 are never taken
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd <= tension_pkg::RST_ZERO;
            for (int i = 3; i < 16; i++) begin
                cfg[i] <= tension_pkg::RST_ZERO;
            end
            cfg[tension_pkg::OFS_HI_STOP_LSB] <= tension_pkg::RST_HI_STOP_LSB;
            cfg[tension_pkg::OFS_LO_STOP_MSB] <= tension_pkg::RST_LO_STOP;
            cfg[tension_pkg::OFS_LO_STOP_LSB] <= tension_pkg::RST_LO_STOP;
            cfg[tension_pkg::OFS_FILTER] <= tension_pkg::RST_FILTER;
        end else if (area_write) begin
            cmd <= shadow[tension_pkg::OFS_CMD];
            for (int i = 3; i < 16; i++) begin
                cfg[i] <= shadow[i];
            end
        end
    end

    // stop limit in a reporting mode halts measuring until the host writes
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            halted_o <= 1'b0;
        end else if (stitch_done && mode[1]
                     && (status[tension_pkg::STAT_HI_STOP] || status[tension_pkg::STAT_LO_STOP])) begin
            halted_o <= 1'b1;
        end else if (area_write) begin
            halted_o <= 1'b0;
        end
    end

    // report decision once the flags of the new stitch have settled
    always_comb begin
        case (mode)
            tension_pkg::MODE_EVERY: report_go = stitch_done;
            tension_pkg::MODE_EVENT: report_go = stitch_done && (status[7:4] != 4'h0);
            default: report_go = 1'b0; // off and reserved stay silent
        endcase
    end

    // pending requests; a new request wins over the clear of the same cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            area_pend <= 1'b0;
            report_pend <= 1'b0;
        end else begin
            if (rx_end_i.done) begin
                area_pend <= 1'b1;
            end else if (state == tension_pkg::TX_IDLE) begin
                area_pend <= 1'b0;
            end
            if (report_go) begin
                report_pend <= 1'b1;
            end else if (state == tension_pkg::TX_IDLE && !area_pend) begin
                report_pend <= 1'b0;
            end
        end
    end

    // transmitter: bytes follow back to back while the host takes them
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= tension_pkg::TX_IDLE;
            tx_idx <= 4'h0;
            tx_data_o <= tension_pkg::RST_ZERO;
        end else begin
            case (state)
                tension_pkg::TX_IDLE: begin
                    tx_idx <= 4'h0;
                    if (area_pend) begin
                        state <= tension_pkg::TX_AREA;
                        tx_data_o <= cmd;
                    end else if (report_pend) begin
                        state <= tension_pkg::TX_REPORT;
                        tx_data_o <= status;
                    end
                end
                tension_pkg::TX_AREA: begin
                    if (tx_take) begin
                        tx_idx <= tx_idx + 4'h1;
                        if (tx_idx == tension_pkg::OFS_LAST) begin
                            state <= tension_pkg::TX_IDLE;
                        end else if (tx_idx + 4'h1 == tension_pkg::OFS_STATUS) begin
                            tx_data_o <= status;
                        end else if (tx_idx + 4'h1 == tension_pkg::OFS_TLOW) begin
                            tx_data_o <= tension_low;
                        end else begin
                            tx_data_o <= cfg[tx_idx + 4'h1];
                        end
                    end
                end
                tension_pkg::TX_REPORT: begin
                    if (tx_take) begin
                        tx_idx <= tx_idx + 4'h1;
                        if (tx_idx[1:0] == tension_pkg::REPORT_LAST) begin
                            state <= tension_pkg::TX_IDLE;
                        end else if (tx_idx == 4'h0) begin
                            tx_data_o <= tension_low;
                        end else begin
                            tx_data_o <= report_sum;
                        end
                    end
                end
                default: state <= tension_pkg::TX_IDLE;
            endcase
        end
    end

    // flash timer; a long period so the operator can see it
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flash_cnt <= 32'h0000_0000;
            flash <= 1'b0;
        end else if (flash_cnt >= FLASH_CYCLES - 1) begin
            flash_cnt <= 32'h0000_0000;
            flash <= !flash;
        end else begin
            flash_cnt <= flash_cnt + 32'h0000_0001;
        end
    end

    // alert follows the halt; stop leds flash while halted
    always_comb begin
        alert_o = halted_o;
        led_o = {status[7:6], status[5:4] & {2{!halted_o || flash}}};
    end

    // checks
    a_read_keeps_area: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        rx_end_i.done && shadow[tension_pkg::OFS_CMD][tension_pkg::CMD_READ_BIT]
        |=> $stable(cmd) && $stable(cfg[tension_pkg::OFS_HI_IND_MSB]))
        else $error("read request changed the area");
    a_write_loads_area: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        area_write |=> cfg[tension_pkg::OFS_HI_IND_MSB] == $past(shadow[tension_pkg::OFS_HI_IND_MSB])
        && cmd == $past(shadow[tension_pkg::OFS_CMD]))
        else $error("write message not stored");
    a_echo_starts: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        rx_end_i.done && state == tension_pkg::TX_IDLE
        |=> ##1 state == tension_pkg::TX_AREA && tx_data_o == cmd)
        else $error("area echo did not start");
    a_mode_gates_report: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(report_pend) |-> $past(mode[1]))
        else $error("report raised with reporting off");
    a_every_reports: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        stitch_done && mode == tension_pkg::MODE_EVERY |=> report_pend)
        else $error("stitch report missing");
    a_stop_halts: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        stitch_done && mode[1] && status[5:4] != 2'h0 && !area_write |=> halted_o && alert_o)
        else $error("stop limit did not halt");
    a_halt_freezes: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        halted_o |=> $stable(tension_low) && $stable(tension_hi))
        else $error("tension moved while halted");
    a_tension_split: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        stitch_take |=> status[3:0] == $past(tension_i[11:8])
        && tension_low == $past(tension_i[7:0]))
        else $error("tension bytes wrong");
    a_first_sync_force: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        stitch_take && !first_sync_seen && !comm_seen |=> status[5:4] == 2'h3)
        else $error("stop flags not forced");
    a_report_length: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state == tension_pkg::TX_REPORT && tx_take && tx_idx == 4'h2 |=> state == tension_pkg::TX_IDLE)
        else $error("report not three bytes");
    c_report_sent: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state == tension_pkg::TX_REPORT && tx_take && tx_idx == 4'h2);
    c_area_echo: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state == tension_pkg::TX_AREA && tx_take && tx_idx == tension_pkg::OFS_LAST);
    c_halt: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $rose(halted_o));
    c_force: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $rose(force_stop));
endmodule : tension_area
`default_nettype wire

// ===== test/host_model.sv
// Purpose: host computer model on the far side of the area
// Assumes: serial framing and checksum checks sit upstream of the block
// Notes: idle rx data shows the inverse of the last byte, never a stale copy
`default_nettype none
module host_model (
    // clock
    input wire logic clk_sys_i,
    // bytes offered by the device
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic stall_i,
    // bytes sent to the device
    output var tension_pkg::rx_byte_type rx_o,
    output var tension_pkg::rx_end_type rx_end_o,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed_m = 15; // own stream so stalls repeat
    int cyc = 0; // free cycle stamp
    logic [7:0] got[$]; // bytes taken
    int when[$]; // stamp of each byte taken
    initial begin
        rx_o = '0;
        rx_end_o = '0;
        tx_ready_o = 1'b1;
    end
    // take offered bytes; stall at random only when asked
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
            when.push_back(cyc);
        end
        tx_ready_o <= !stall_i || ($random(seed_m) % 2 != 0);
    end
    // one whole 16 byte message, then the end marker
    task automatic send(input logic [7:0] m[16], input logic good);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            rx_o <= '{1'b1, 4'(i), m[i]};
        end
        @(posedge clk_sys_i);
        rx_o <= '{1'b0, 4'hF, ~m[15]};
        rx_end_o <= '{1'b1, good};
        @(posedge clk_sys_i);
        rx_end_o <= '0;
    endtask : send
endmodule : host_model
`default_nettype wire

// ===== test/tb_tension_area.sv
// Purpose: self-checking bench for the tension status area
// Assumes: led flash shortened to four cycles
// Notes: expectations come from a bench copy of the 16 byte area
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb_tension_area;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sync_i = 1'b0;
    logic [11:0] tension_i = 12'h000;
    logic stall = 1'b0; // host stalls during echoes only
    tension_pkg::rx_byte_type rx_i;
    tension_pkg::rx_end_type rx_end_i;
    logic tx_ready_i, tx_valid_o, alert_o, halted_o;
    logic [7:0] tx_data_o;
    logic [3:0] led_o;
    int mismatches = 0;
    int num_checks = 0;
    int seed = 15;
    logic [7:0] img[16]; // bench copy of the area
    logic [7:0] msg[16]; // next host message
    int run[4]; // out of limit streaks: high ind, low ind, high stop, low stop
    logic talked, first, halted;
    logic [11:0] corner[5] = '{12'h200, 12'h201, 12'h100, 12'h0FF, 12'h040};
    tension_area #(.FLASH_CYCLES(4)) uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .sync_i(sync_i), .tension_i(tension_i), .rx_i(rx_i), .rx_end_i(rx_end_i),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
        .alert_o(alert_o), .halted_o(halted_o), .led_o(led_o));
    host_model host (.clk_sys_i(clk_sys_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .stall_i(stall), .rx_o(rx_i), .rx_end_o(rx_end_i), .tx_ready_o(tx_ready_i));
    // 25 MHz clock
    initial forever #20 clk_sys_i = ~clk_sys_i;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // expected report checksum: plain byte sum of status and tension low
    function automatic logic [7:0] exp_sum(input logic [7:0] st, input logic [7:0] lo);
        return st + lo;
    endfunction : exp_sum
    task automatic done(input string s);
        $display("test %s finished, checks so far %0d", s, num_checks);
    endtask : done
    // reset for 8 cycles and reload the bench image with power-on values
    task automatic do_reset();
        sys_rst_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        img = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF, 8'hFF,
            8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        run = '{0, 0, 0, 0};
        talked = 1'b0;
        first = 1'b1;
        halted = 1'b0;
    endtask : do_reset
    // send msg and compare the whole echo with the image
    task automatic xfer(input logic good);
        int n;
        n = 0;
        host.got.delete();
        stall = 1'b1;
        talked = 1'b1;
        host.send(msg, good);
        if (good && !msg[0][5]) begin
            foreach (img[i]) if (i != 1 && i != 2) img[i] = msg[i];
            halted = 1'b0;
        end
        while (host.got.size() < 16 && n < 400) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n == 400) begin
            mismatches++;
            tally_and_finish();
        end
        foreach (img[i]) `CHK("echo byte", img[i], host.got[i])
        stall = 1'b0;
    endtask : xfer
    // random message body; rd picks read-only echo
    task automatic fill(input logic rd);
        foreach (msg[i]) msg[i] = 8'($random(seed));
        msg[0][5] = rd;
    endtask : fill
    // good writing message with fixed limits: low ind 100, high stop E00, low stop 40
    task automatic setup(input logic [7:0] cmd, input logic [15:0] hind, input logic [7:0] filt);
        fill(1'b0);
        msg[0] = cmd;
        {msg[3], msg[4]} = hind;
        {msg[5], msg[6], msg[7], msg[8], msg[9], msg[10]} = 48'h0100_0E00_0040;
        msg[13] = filt;
        msg[14] = 8'h00;
        xfer(1'b1);
    endtask : setup
    // one stitch; the expected status is worked out before the pulse
    task automatic stitch(input logic [11:0] t);
        logic [7:0] st;
        logic [15:0] v;
        logic [15:0] lim[4];
        logic [3:0] n;
        logic rep;
        logic [1:0] seen; // stop leds seen lit, seen dark
        rep = 1'b0;
        if (!halted) begin
            v = {4'h0, t};
            lim = '{{img[3], img[4]}, {img[5], img[6]}, {img[7], img[8]}, {img[9], img[10]}};
            n = (img[13][3:0] == 4'h0) ? 4'h1 : img[13][3:0];
            st = {4'h0, t[11:8]};
            for (int k = 0; k < 4; k++) begin
                run[k] = (lim[k] != 0 && ((k % 2 == 0) ? v > lim[k] : v < lim[k])) ? run[k] + 1 : 0;
                st[7 - k] = (run[k] >= n);
            end
            if (first && !talked) st[5:4] = 2'b11;
            rep = img[0][7] && (!img[0][6] || st[7:4] != 4'h0);
            img[1] = st;
            img[2] = t[7:0];
            first = 1'b0;
            halted = img[0][7] && st[5:4] != 2'b00;
        end
        host.got.delete();
        host.when.delete();
        tension_i <= t;
        sync_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        sync_i <= 1'b0;
        tension_i <= ~t;
        repeat (12) @(posedge clk_sys_i);
        `CHK("report count", (rep ? 3 : 0), host.got.size())
        if (rep && host.got.size() == 3) begin
            `CHK("report", ({img[1], img[2], exp_sum(img[1], img[2])}), ({host.got[0], host.got[1], host.got[2]}))
            `CHK("report gap", 2, host.when[2] - host.when[0])
        end
        `CHK("halted", halted, halted_o)
        `CHK("alert", halted, alert_o)
        `CHK("ind leds", img[1][7:6], led_o[3:2])
        if (!halted) `CHK("stop leds", img[1][5:4], led_o[1:0])
        // while halted the stop leds must blink: both phases within ten cycles, just over one flash period
        if (halted) begin
            seen = 2'b00;
            repeat (10) begin
                @(posedge clk_sys_i);
                seen = seen | {led_o[1:0] == img[1][5:4], led_o[1:0] == 2'b00};
            end
            `CHK("stop led flash", 2'b11, seen)
        end
    endtask : stitch
    // main sequence
    initial begin
        do_reset();
        stitch(12'h000);
        fill(1'b1);
        xfer(1'b1);
        done("forced stop flags");
        do_reset();
        fill(1'b1);
        xfer(1'b1);
        fill(1'b0);
        xfer(1'b0);
        done("reset values and refusal");
        setup(8'h80, 16'h0200, 8'h01);
        foreach (corner[i]) stitch(corner[i]);
        repeat (10) stitch((12'($random(seed)) & 12'hCFF) | 12'h040);
        done("every stitch");
        stitch(12'hE01);
        stitch(12'h100);
        done("stop limit halt");
        setup(8'hC0, 16'h0000, 8'h03);
        stitch(12'h300);
        repeat (3) stitch(12'h080);
        done("event mode and filter");
        for (int m = 0; m < 4; m++) begin
            setup({2'(m), 6'h00}, 16'h0200, 8'h01);
            stitch(12'h080);
        end
        done("report modes");
        tally_and_finish();
    end
endmodule : tb_tension_area
`default_nettype wire
